// *** design/exs_unit.sv ***
// Exception entry and return state logic with an AHB-Lite register window.
// Assumes completion logic on the same clock reports retirement and faults at the oldest
// instruction, and that it flushes younger work when the redirect pulse appears.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module exs_unit (
  input wire logic clock,
  input wire logic rst_n,
  input wire exs_pkg::exs_ahb_req_t ahb_req,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire exs_pkg::exs_retire_t retire,
  input wire exs_pkg::exs_fault_t fault,
  input wire exs_pkg::exs_events_t events,
  output logic redirect,
  output exs_pkg::exs_cause_t redirect_cause,
  output logic flush_younger,
  output logic float_dispatch_block,
  output logic float_exc_precise,
  output logic checkstop,
  output exs_pkg::exs_ctrl_t ctrl,
  output logic [31:0] resume_pc_out
);
  import exs_pkg::*;

  // Architectural state.
  logic [31:0] machine_state_word;
  logic [31:0] saved_status_word;
  logic [31:0] resume_pc_save;
  logic [31:0] next_machine_state_word;
  logic [31:0] next_saved_status_word;
  logic [31:0] next_resume_pc_save;

  // Bus data phase state.
  logic wr_pending;
  logic [7:0] wr_offset;
  logic next_wr_pending;
  logic [7:0] next_wr_offset;
  logic [31:0] next_hrdata;

  // Registered outputs.
  logic next_redirect;
  exs_cause_t next_redirect_cause;
  exs_cause_t last_cause;
  exs_cause_t next_last_cause;
  logic next_checkstop;
  logic next_float_dispatch_block;
  logic next_float_exc_precise;

  // Decision signals.
  exs_cause_t take_cause;
  logic [31:0] take_pc;
  logic [5:0] take_info;
  logic addr_phase;
  logic [31:0] state_view;

  // Read image of the state word: unimplemented bits always read zero.
  function automatic logic [31:0] state_image(input logic [31:0] raw);
    state_image = raw & STATE_WRITE_MASK;
  endfunction

  // Save image: copied state bits plus the cause information.
  function automatic logic [31:0] save_image(input logic [31:0] raw, input logic [5:0] info);
    logic [31:0] img;
    img = raw & SAVE_COPY_MASK;
    img[INFO_HI_POS +: 3] = info[5:3];
    img[INFO_LO_POS +: 3] = info[2:0];
    save_image = img;
  endfunction

  // Register read decode, used by the bus read path.
  function automatic logic [31:0] read_reg(input logic [7:0] ofs, input logic [31:0] msw,
                                           input logic [31:0] ssw, input logic [31:0] rpc,
                                           input logic cs, input exs_cause_t cause);
    logic [31:0] val;
    val = 32'h0000_0000;
    case (ofs)
      OFS_MACHINE_STATE: begin
        val = state_image(msw);
      end
      OFS_SAVED_STATUS: begin
        val = ssw;
      end
      OFS_RESUME_PC: begin
        val = rpc;
      end
      OFS_UNIT_STATUS: begin
        val[POS_CHECKSTOP] = cs;
        val[3:0] = cause;
      end
      default: begin
        val = 32'h0000_0000;
      end
    endcase
    read_reg = val;
  endfunction

  assign state_view = state_image(machine_state_word);

  // Exception selection. Only one exception is taken per cycle, ranked machine check first;
  // faults are reported at the oldest instruction, so everything older has completed and
  // nothing younger has started when the choice is made.
  always_comb begin
    take_cause = CAUSE_NONE;
    take_pc = fault.pc;
    take_info = 6'h00;
    next_checkstop = checkstop;
    if (!checkstop) begin
      if (events.mcheck) begin
        if (state_view[POS_MCHECK_EN]) begin
          take_cause = CAUSE_MCHECK;
          take_pc = retire.valid ? retire.next_pc : fault.pc;
        end else begin
          next_checkstop = 1'b1;
        end
      end else if (fault.valid) begin
        take_cause = fault.cause;
        take_info = fault.info;
        // A trace reported through the fault path also resumes after the instruction.
        if (fault.cause == CAUSE_SYSTEM_CALL || fault.cause == CAUSE_TRAP
            || fault.cause == CAUSE_TRACE) begin
          take_pc = fault.next_pc;
        end else begin
          take_pc = fault.pc;
        end
      end else if (events.float_enabled && state_view[POS_FLOAT_AVAIL]
                   && (state_view[POS_FEXC_MODE_A] || state_view[POS_FEXC_MODE_B])) begin
        take_cause = CAUSE_FLOAT_PROGRAM;
        take_pc = fault.pc;
      end else if (retire.valid && state_view[POS_STEP_TRACE] && !retire.raised
                   && !retire.is_return && !retire.is_sync && !retire.is_system_call) begin
        take_cause = CAUSE_TRACE;
        take_pc = retire.next_pc;
      end else if (state_view[POS_ASYNC_IRQ_EN] && events.external) begin
        take_cause = CAUSE_EXTERNAL;
        take_pc = retire.valid ? retire.next_pc : fault.pc;
      end else if (state_view[POS_ASYNC_IRQ_EN] && events.decrementer) begin
        take_cause = CAUSE_DECREMENTER;
        take_pc = retire.valid ? retire.next_pc : fault.pc;
      end
    end
  end

  // Bus address phase is a valid non-sequential transfer selected on a ready cycle.
  assign addr_phase = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == HTRANS_NONSEQ);

  // Next state of the architectural registers. Hardware updates beat a software write
  // in the same cycle, since losing a save would make the handler unrecoverable.
  always_comb begin
    next_machine_state_word = machine_state_word;
    next_saved_status_word = saved_status_word;
    next_resume_pc_save = resume_pc_save;
    next_redirect = 1'b0;
    next_redirect_cause = redirect_cause;
    next_last_cause = last_cause;
    if (wr_pending) begin
      case (wr_offset)
        OFS_MACHINE_STATE: begin
          next_machine_state_word = state_image(ahb_req.hwdata);
        end
        OFS_SAVED_STATUS: begin
          next_saved_status_word = ahb_req.hwdata;
        end
        OFS_RESUME_PC: begin
          next_resume_pc_save = ahb_req.hwdata;
        end
        default: begin
          next_resume_pc_save = resume_pc_save;
        end
      endcase
    end
    if (take_cause != CAUSE_NONE) begin
      // Both saves and the redirect land on the same edge.
      next_resume_pc_save = take_pc;
      next_saved_status_word = save_image(state_view, take_info);
      next_machine_state_word = state_view;
      next_machine_state_word[POS_ASYNC_IRQ_EN] = 1'b0;
      next_machine_state_word[POS_LSB_FIRST] = state_view[POS_EXC_BYTE_ORDER];
      next_redirect = 1'b1;
      next_redirect_cause = take_cause;
      next_last_cause = take_cause;
    end else if (retire.valid && retire.is_return && !checkstop) begin
      next_machine_state_word = state_image(saved_status_word);
    end
  end

  // Derived control levels, registered so each output leaves a flip-flop.
  always_comb begin
    next_float_dispatch_block = !next_machine_state_word[POS_FLOAT_AVAIL];
    next_float_exc_precise = next_machine_state_word[POS_FEXC_MODE_A]
                             || next_machine_state_word[POS_FEXC_MODE_B];
  end

  // Control word view taken straight from the state register bits.
  always_comb begin
    ctrl.low_energy_enable = machine_state_word[POS_LOW_ENERGY];
    ctrl.async_interrupt_enable = machine_state_word[POS_ASYNC_IRQ_EN];
    ctrl.user_mode_flag = machine_state_word[POS_USER_MODE];
    ctrl.float_unit_available = machine_state_word[POS_FLOAT_AVAIL];
    ctrl.mcheck_enable = machine_state_word[POS_MCHECK_EN];
    ctrl.float_exc_mode_a = machine_state_word[POS_FEXC_MODE_A];
    ctrl.float_exc_mode_b = machine_state_word[POS_FEXC_MODE_B];
    ctrl.step_trace_enable = machine_state_word[POS_STEP_TRACE];
    ctrl.lsb_first_order = machine_state_word[POS_LSB_FIRST];
  end

  // Bus slave: zero wait states, so read data is fetched at the address phase.
  // A read issued in the cycle of an exception returns the value before the save.
  always_comb begin
    next_wr_pending = addr_phase && ahb_req.hwrite;
    next_wr_offset = ahb_req.haddr[7:0];
    next_hrdata = hrdata;
    if (addr_phase && !ahb_req.hwrite) begin
      if (ahb_req.haddr[31:8] == 24'h00_0000) begin
        next_hrdata = read_reg(ahb_req.haddr[7:0], machine_state_word, saved_status_word,
                               resume_pc_save, checkstop, last_cause);
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
    if (ahb_req.haddr[31:8] != 24'h00_0000) begin
      next_wr_offset = 8'hFF;
    end
  end

  // State registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      machine_state_word <= RESET_MACHINE_STATE;
      saved_status_word <= RESET_SAVE;
      resume_pc_save <= RESET_SAVE;
      redirect <= 1'b0;
      redirect_cause <= CAUSE_NONE;
      last_cause <= CAUSE_NONE;
      checkstop <= 1'b0;
      float_dispatch_block <= 1'b1;
      float_exc_precise <= 1'b0;
    end else begin
      machine_state_word <= next_machine_state_word;
      saved_status_word <= next_saved_status_word;
      resume_pc_save <= next_resume_pc_save;
      redirect <= next_redirect;
      redirect_cause <= next_redirect_cause;
      last_cause <= next_last_cause;
      checkstop <= next_checkstop;
      float_dispatch_block <= next_float_dispatch_block;
      float_exc_precise <= next_float_exc_precise;
    end
  end

  // Bus registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pending <= 1'b0;
      wr_offset <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pending <= next_wr_pending;
      wr_offset <= next_wr_offset;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // The flush follows the redirect so younger work never starts in the handler's place.
  assign flush_younger = redirect;
  assign resume_pc_out = resume_pc_save;

endmodule

`default_nettype wire

// *** design/exs_pkg.sv ***
// Constants, field layouts and carrier types for the exception state save unit.
// Assumes one core clock and a pipeline that reports retirement and faults on that clock.
// Architectural bit n of a state word sits at vector index 31 - n.
// Behaviour
// - Taking any exception saves the resume address and the machine state.
// - Resume at the faulting instruction, or the next one for system call, trace, trap.
// - At entry all older instructions completed and no younger one has started.
// - The resume address save register is a full 32-bit address.
// - Status is saved at entry and copied back by the return instruction.
// - Save bits 2-4 and 10-12 carry cause-specific information.
// - State bits 5-9 and 16-31 are copied to the same save positions.
// - Bits 0 and 5-9 are full-function reserved; 1-4 and 10-12 partial.
// - Bit 13 enables the reduced-power mode when set.
// - At entry bit 15 is copied into the byte-order bit.
// - Bit 16 gates external and decrementer interrupts.
// - Bit 17 set restricts execution to user-level instructions.
// - Bit 18 clear blocks dispatch of every floating-point instruction.
// - Bit 18 set allows floating-point execution and its enabled exceptions.
// - Bit 19 enables machine-check exceptions.
// - Bit 20 is the first floating-point exception mode bit.
// - Bit 21 traps after each instruction except return, synchronise and system call.
// - An instruction counts as successful only if it raised no other exception.
// - Bit 14 reserved; bits 0 to 12 read as zero.
// - Full-function reserved bits are saved, partial-function ones are not.
// - Interrupt enable clear delays interrupts and is cleared on every exception.
// - Both mode bits clear ignore float exceptions, otherwise they are precise.
// - A machine check with checking disabled enters checkstop instead.
package exs_pkg;

  // Register byte offsets on the AHB-Lite window.
  localparam logic [7:0] OFS_MACHINE_STATE = 8'h00;
  localparam logic [7:0] OFS_SAVED_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESUME_PC = 8'h08;
  localparam logic [7:0] OFS_UNIT_STATUS = 8'h0C;

  // Vector positions of the machine state word fields.
  localparam int POS_LOW_ENERGY = 18;
  localparam int POS_EXC_BYTE_ORDER = 16;
  localparam int POS_ASYNC_IRQ_EN = 15;
  localparam int POS_USER_MODE = 14;
  localparam int POS_FLOAT_AVAIL = 13;
  localparam int POS_MCHECK_EN = 12;
  localparam int POS_FEXC_MODE_A = 11;
  localparam int POS_STEP_TRACE = 10;
  localparam int POS_FEXC_MODE_B = 8;
  localparam int POS_LSB_FIRST = 0;

  // Save image: full-function reserved bits and the upper state bits are kept.
  localparam logic [31:0] SAVE_COPY_MASK = 32'h87C0_FFFF;
  // Save image positions that take the cause-specific information.
  localparam logic [31:0] SAVE_INFO_MASK = 32'h3838_0000;
  localparam int INFO_HI_POS = 27;
  localparam int INFO_LO_POS = 19;
  // State word bits that hold storage; bits 0 to 12, 14, 24 and 28 read zero.
  localparam logic [31:0] STATE_WRITE_MASK = 32'h0005_FF77;

  // Reset values.
  localparam logic [31:0] RESET_MACHINE_STATE = 32'h0000_0000;
  localparam logic [31:0] RESET_SAVE = 32'h0000_0000;

  // Unit status register field positions.
  localparam int POS_CHECKSTOP = 31;

  // Exception causes; the unit ranks machine check, then any reported fault, float program, trace, external, decrementer.
  typedef enum logic [3:0] {
    CAUSE_NONE,
    CAUSE_MCHECK,
    CAUSE_ILLEGAL,
    CAUSE_TRAP,
    CAUSE_SYSTEM_CALL,
    CAUSE_FLOAT_UNAVAIL,
    CAUSE_FLOAT_PROGRAM,
    CAUSE_OTHER_SYNC,
    CAUSE_TRACE,
    CAUSE_EXTERNAL,
    CAUSE_DECREMENTER
  } exs_cause_t;

  // One retiring instruction as reported by completion.
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic is_return;
    logic is_sync;
    logic is_system_call;
    logic raised;
  } exs_retire_t;

  // A synchronous fault reported against the oldest instruction.
  typedef struct packed {
    logic valid;
    exs_cause_t cause;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic [5:0] info;
  } exs_fault_t;

  // Asynchronous and floating-point condition lines.
  typedef struct packed {
    logic mcheck;
    logic external;
    logic decrementer;
    logic float_enabled;
  } exs_events_t;

  // Control levels that steer the rest of the core.
  typedef struct packed {
    logic low_energy_enable;
    logic async_interrupt_enable;
    logic user_mode_flag;
    logic float_unit_available;
    logic mcheck_enable;
    logic float_exc_mode_a;
    logic float_exc_mode_b;
    logic step_trace_enable;
    logic lsb_first_order;
  } exs_ctrl_t;

  // AHB-Lite request side.
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } exs_ahb_req_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// *** tb/exs_pipe_model.sv ***
// Behavioural model of the pipeline and exception sources beside the unit.
// Assumes the bench calls issue once per report and checks the answer after it.
`timescale 1ns/1ps
`default_nettype none
module exs_pipe_model (
  input wire logic clock,
  output var exs_pkg::exs_retire_t retire,
  output var exs_pkg::exs_fault_t fault,
  output var exs_pkg::exs_events_t events
);
  import exs_pkg::*;
  // Quiet at time zero so that nothing is reported before the first request.
  initial begin
    retire = '0;
    fault = '0;
    events = '0;
  end
  // A report stands one cycle; then its payload is scrambled so stale fields cannot pass.
  task automatic issue(input exs_retire_t r, input exs_fault_t f, input exs_events_t e);
    exs_retire_t rq;
    exs_fault_t fq;
    rq = exs_retire_t'(~r);
    rq.valid = 1'b0;
    fq = exs_fault_t'(~f);
    fq.valid = 1'b0;
    @(posedge clock);
    retire <= r;
    fault <= f;
    events <= e;
    @(posedge clock);
    retire <= rq;
    fault <= fq;
    events <= '0;
  endtask
endmodule
`default_nettype wire

// *** tb/exs_unit_properties.sv ***
// Concurrent checks on the ports of the exception state save unit.
// Assumes the bind below attaches it to every instance of the unit.
`timescale 1ns/1ps
`default_nettype none
module exs_unit_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire exs_pkg::exs_retire_t retire,
  input wire exs_pkg::exs_fault_t fault,
  input wire exs_pkg::exs_events_t events,
  input wire logic redirect,
  input wire exs_pkg::exs_cause_t redirect_cause,
  input wire logic flush_younger,
  input wire logic float_dispatch_block,
  input wire logic checkstop,
  input wire exs_pkg::exs_ctrl_t ctrl,
  input wire logic [31:0] resume_pc_out
);
  import exs_pkg::*;
  logic live;
  // Entry is predictable only while no machine check competes and the core still runs.
  assign live = !checkstop && !events.mcheck;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Each check ties an output to the request, state level or other output that decides it.
  a_flush_tracks_redirect: assert property (flush_younger == redirect)
    else $error("flush differs from redirect");
  a_trap_resume_next: assert property (fault.valid && fault.cause == CAUSE_TRAP && live
    |=> redirect && resume_pc_out == $past(fault.next_pc)) else $error("trap resume wrong");
  a_entry_masks_irq: assert property ($rose(redirect) |-> !ctrl.async_interrupt_enable)
    else $error("interrupt enable kept at entry");
  a_irq_held_off: assert property (!ctrl.async_interrupt_enable && !fault.valid
    && !retire.valid && !events.mcheck && !events.float_enabled |=> !redirect)
    else $error("masked interrupt taken");
  a_fpu_block_level: assert property ($stable(ctrl.float_unit_available)
    |-> float_dispatch_block == !ctrl.float_unit_available) else $error("float block wrong");
  a_mcheck_taken: assert property (events.mcheck && ctrl.mcheck_enable && !checkstop
    |=> redirect && redirect_cause == CAUSE_MCHECK) else $error("machine check not taken");
  a_checkstop_entry: assert property (events.mcheck && !ctrl.mcheck_enable
    |=> checkstop [*2]) else $error("checkstop not entered");
  a_trace_after_step: assert property (retire.valid && ctrl.step_trace_enable
    && !retire.raised && !retire.is_return && !retire.is_sync && !retire.is_system_call
    && live |=> redirect) else $error("step trace missing");
  a_trace_needs_success: assert property (retire.valid && retire.raised
    && !fault.valid && events == '0 |=> !redirect) else $error("trace after failed step");
endmodule
bind exs_unit exs_unit_properties u_props (
  .clock(clock), .rst_n(rst_n), .retire(retire), .fault(fault), .events(events),
  .redirect(redirect), .redirect_cause(redirect_cause), .flush_younger(flush_younger),
  .float_dispatch_block(float_dispatch_block), .checkstop(checkstop), .ctrl(ctrl),
  .resume_pc_out(resume_pc_out)
);
`default_nettype wire

// *** tb/exs_unit_test.sv ***
// Self-checking bench for the exception state save unit.
// Assumes the register window at the package offsets and zero-wait AHB-Lite answers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module exs_unit_test;
  import exs_pkg::*;
  logic clock, rst_n, hreadyout, hresp, redirect, flush_younger, checkstop;
  logic float_dispatch_block, float_exc_precise;
  logic [31:0] hrdata, resume_pc_out, s;
  exs_ahb_req_t m;
  exs_retire_t retire;
  exs_fault_t fault;
  exs_events_t events;
  exs_cause_t redirect_cause;
  exs_ctrl_t ctrl;
  int bad_count = 0;
  int samples_checked = 0;
  // The bus hready is the slave's own hreadyout.
  exs_unit dut (
    .clock(clock), .rst_n(rst_n), .ahb_req(exs_ahb_req_t'({m[71:1], hreadyout})),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .retire(retire),
    .fault(fault), .events(events), .redirect(redirect), .redirect_cause(redirect_cause),
    .flush_younger(flush_younger), .float_dispatch_block(float_dispatch_block),
    .float_exc_precise(float_exc_precise), .checkstop(checkstop), .ctrl(ctrl),
    .resume_pc_out(resume_pc_out)
  );
  exs_pipe_model p (.clock(clock), .retire(retire), .fault(fault), .events(events));
  // Free-running core clock, 40 ns period.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    end_sim();
  end
  task automatic end_sim();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // One single AHB-Lite word transfer; the master waits on hready in both phases.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    m <= '{1'b1, {24'h0, a}, HTRANS_NONSEQ, w, 3'h2, m.hwdata, 1'b1};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    m.htrans <= 2'h0;
    m.hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e);
    `CHK(hresp, 1'b0);
  endtask
  // The answer lands on the taking edge, so look just after it.
  task automatic go(input exs_retire_t r, input exs_fault_t f, input exs_events_t e);
    p.issue(r, f, e);
    #1;
  endtask
  // Redirect stands one cycle only, so it is judged in that cycle.
  task automatic seen(input logic x, input exs_cause_t c);
    `CHK(redirect, x);
    if (x) begin
      `CHK(redirect_cause, c);
    end
  endtask
  // Architectural bit n lives at vector index 31 - n.
  function automatic logic [31:0] ab(input int n);
    return 32'h1 << (31 - n);
  endfunction
  function automatic logic [31:0] img(input logic [31:0] st, input logic [5:0] i);
    return (st & SAVE_COPY_MASK) | (32'(i[5:3]) << (31 - 4)) | (32'(i[2:0]) << (31 - 12));
  endfunction
  // Main sequence; checkstop comes last because nothing is taken after it.
  initial begin
    m = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFS_MACHINE_STATE, RESET_MACHINE_STATE);
    `CHK(float_dispatch_block, 1'b1);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    wr(OFS_MACHINE_STATE, 32'hFFFF_FFFF);
    rd(OFS_MACHINE_STATE, STATE_WRITE_MASK);
    `CHK(ctrl, 9'h1FF);
    `CHK(float_dispatch_block, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MACHINE_STATE, ab(18) | (i[1] ? ab(20) : 32'h0) | (i[0] ? ab(23) : 32'h0));
      go('0, '0, '{1'b0, 1'b0, 1'b0, 1'b1});
      seen(i != 0, CAUSE_FLOAT_PROGRAM);
      `CHK(float_exc_precise, i != 0);
    end
    s = ab(15) | ab(16) | ab(19) | ab(27);
    wr(OFS_MACHINE_STATE, s);
    go('0, '{1'b1, CAUSE_TRAP, 32'h1000, 32'h1004, 6'h2D}, '0);
    seen(1'b1, CAUSE_TRAP);
    `CHK(resume_pc_out, 32'h1004);
    rd(OFS_RESUME_PC, 32'h1004);
    rd(OFS_SAVED_STATUS, img(s, 6'h2D));
    rd(OFS_MACHINE_STATE, (s & ~ab(16)) | ab(31));
    go('0, '{1'b1, CAUSE_ILLEGAL, 32'hFFFF_FFFC, 32'h0, 6'h0}, '0);
    `CHK(resume_pc_out, 32'hFFFF_FFFC);
    go('0, '{1'b1, CAUSE_SYSTEM_CALL, 32'h0500, 32'h0504, 6'h0}, '0);
    `CHK(resume_pc_out, 32'h0504);
    wr(OFS_SAVED_STATUS, ab(16) | ab(18));
    go('{1'b1, 32'h2000, 32'h2004, 1'b1, 1'b0, 1'b0, 1'b0}, '0, '0);
    rd(OFS_MACHINE_STATE, ab(16) | ab(18));
    for (int j = 0; j < 2; j++) begin
      wr(OFS_MACHINE_STATE, ab(16));
      go('0, '0, '{1'b0, j == 0, j == 1, 1'b0});
      seen(1'b1, j == 0 ? CAUSE_EXTERNAL : CAUSE_DECREMENTER);
      go('0, '0, '{1'b0, j == 0, j == 1, 1'b0});
      seen(1'b0, CAUSE_NONE);
    end
    for (int k = 0; k < 4; k++) begin
      wr(OFS_MACHINE_STATE, ab(21));
      go('{1'b1, 32'h3000, 32'h3004, 1'b0, k == 0, k == 1, k == 2}, '0, '0);
      seen(k == 3, CAUSE_TRACE);
    end
    `CHK(resume_pc_out, 32'h3004);
    wr(OFS_MACHINE_STATE, ab(19));
    go('0, '0, '{1'b1, 1'b0, 1'b0, 1'b0});
    seen(1'b1, CAUSE_MCHECK);
    wr(OFS_MACHINE_STATE, 32'h0);
    go('0, '0, '{1'b1, 1'b0, 1'b0, 1'b0});
    `CHK(checkstop, 1'b1);
    go('0, '{1'b1, CAUSE_ILLEGAL, 32'h10, 32'h14, 6'h0}, '0);
    seen(1'b0, CAUSE_NONE);
    rd(OFS_UNIT_STATUS, (32'h1 << POS_CHECKSTOP) | 32'(CAUSE_MCHECK));
    end_sim();
  end
endmodule
`default_nettype wire
